// >>> eer_params.svh
/*
 * Constants for the error and event routing block: register offsets, field
 * positions and reset values. Assumes an 8-bit register address space
 * with 16-bit registers, as served by the device's serial register engine.
 */
// Summary of operation
// - Routing bit 15 set: under-range errors appear in that channel's result word.
// - Routing bit 14 set: over-range errors appear in that channel's result word.
// - Routing bit 13 set: watchdog timeouts appear in that channel's result word.
// - Routing bit 12 set: amplitude-high errors set the channel's amplitude result flag.
// - Routing bit 11 set: amplitude-low errors set the channel's amplitude result flag.
// - Routing bit 7 set: under-range drives interrupt and status under-range flag.
// - Routing bit 6 set: over-range drives interrupt and status over-range flag.
// - Routing bit 5 set: watchdog timeout drives interrupt and status timeout flag.
// - Routing bit 4 set: amplitude-high drives interrupt and status flag.
// - Routing bit 3 set: amplitude-low drives interrupt and status flag.
// - Routing bit 2 set: zero-count drives interrupt and status flag.
// - Routing bit 0 set: new result drives interrupt and data-ready flag.
// - Status errors stay latched until status or error channel result read.
// - Status bits 15:14 name the channel that raised the latched error.
// - Data-ready means one result single-channel, all active channels sequential.
// - Interrupt disable holds the interrupt pin high.
`ifndef EER_PARAMS_SVH
`define EER_PARAMS_SVH

`define EER_ADDR_RESULT_HI0 8'h00
`define EER_ADDR_RESULT_STEP 8'h02
`define EER_ADDR_STATUS     8'h18
`define EER_ADDR_ROUTING    8'h19
`define EER_ROUTING_RESET   16'h0000

`define EER_B_UR_TO_RESULT  15
`define EER_B_OR_TO_RESULT  14
`define EER_B_WD_TO_RESULT  13
`define EER_B_AH_TO_RESULT  12
`define EER_B_AL_TO_RESULT  11
`define EER_B_UR_TO_IRQ     7
`define EER_B_OR_TO_IRQ     6
`define EER_B_WD_TO_IRQ     5
`define EER_B_AH_TO_IRQ     4
`define EER_B_AL_TO_IRQ     3
`define EER_B_ZC_TO_IRQ     2
`define EER_B_RDY_TO_IRQ    0

// Positions inside the 7-bit status flag vector
`define EER_F_UR  6
`define EER_F_OR  5
`define EER_F_WD  4
`define EER_F_AH  3
`define EER_F_AL  2
`define EER_F_ZC  1
`define EER_F_RDY 0

`endif

// >>> eer_pkg.sv
/*
 * Types shared by the error and event routing block.
 * Assumes four conversion channels and 16-bit registers.
 */
`default_nettype none
package eer_pkg;
    typedef logic [15:0] eer_word_t;
    typedef logic [7:0]  eer_addr_t;
    typedef logic [1:0]  eer_chan_t;

    typedef struct packed {
        eer_word_t  routing;
        eer_chan_t  src_chan;
        logic [3:0] seen;
        eer_word_t  rdata;
        logic       hit;
        logic       irq_n;
    } eer_state_s;
endpackage
`default_nettype wire

// >>> eer_flag_latch.sv
/*
 * Sticky flag vector: a set pulse latches a bit, a clear pulse drops it.
 * Assumes set and clear are synchronous one-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module eer_flag_latch #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    output logic      [WIDTH-1:0] flags
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } eer_latch_s;

    eer_latch_s st_q;
    eer_latch_s st_d;

    // Set wins so an event landing in the clearing cycle is kept
    always_comb begin
        st_d.flags = (st_q.flags & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;
endmodule
`default_nettype wire

// >>> eer_top.sv
/*
 * Error and event routing: the routing register, status flags with error
 * source channel, per-channel result word error flags and the interrupt pin.
 * Assumes the register engine gives one-cycle read and write strobes with
 * an address, and the converter core gives one-cycle event strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "eer_params.svh"
module eer_top (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire eer_pkg::eer_addr_t   reg_addr,
    input  wire eer_pkg::eer_word_t   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output eer_pkg::eer_word_t        reg_rdata,
    output logic                      reg_hit,
    input  wire logic                 evt_valid,
    input  wire eer_pkg::eer_chan_t   evt_channel,
    input  wire logic                 evt_underrange,
    input  wire logic                 evt_overrange,
    input  wire logic                 evt_timeout,
    input  wire logic                 evt_amp_high,
    input  wire logic                 evt_amp_low,
    input  wire logic                 evt_zero_count,
    input  wire logic                 conv_done,
    input  wire eer_pkg::eer_chan_t   conv_channel,
    input  wire logic                 sequential_mode,
    input  wire logic [3:0]           active_channels,
    input  wire logic                 irq_pin_disable,
    output logic [3:0]                result_underrange_flag,
    output logic [3:0]                result_overrange_flag,
    output logic [3:0]                result_timeout_flag,
    output logic [3:0]                result_amplitude_flag,
    output eer_pkg::eer_word_t        status_word,
    output logic                      interrupt_out_n
);
    function automatic eer_pkg::eer_addr_t result_hi_addr(input eer_pkg::eer_chan_t ch);
        result_hi_addr = `EER_ADDR_RESULT_HI0 + (`EER_ADDR_RESULT_STEP * {6'h00, ch});
    endfunction

    eer_pkg::eer_state_s st_q;
    eer_pkg::eer_state_s st_d;

    logic [6:0]  st_flags;
    logic [6:0]  st_set;
    logic [6:0]  st_clr;
    logic [15:0] res_flags;
    logic [15:0] res_set;
    logic [15:0] res_clr;
    logic        status_rd;
    logic        src_chan_rd;
    logic        data_ready_evt;
    logic [3:0]  seen_now;
    logic [3:0]  conv_onehot;
    logic [3:0]  evt_onehot;
    eer_pkg::eer_word_t rt;

    assign rt          = st_q.routing;
    assign status_rd   = reg_rd && (reg_addr == `EER_ADDR_STATUS);
    assign src_chan_rd = reg_rd && (reg_addr == result_hi_addr(st_q.src_chan));
    assign conv_onehot = 4'h1 << conv_channel;
    assign evt_onehot  = 4'h1 << evt_channel;
    assign seen_now    = st_q.seen | (conv_done ? conv_onehot : 4'h0);

    // One result in single mode; a full sweep of active channels in sequential mode
    assign data_ready_evt = conv_done &&
        (!sequential_mode || ((seen_now & active_channels) == active_channels));

    always_comb begin
        st_set = '0;
        st_set[`EER_F_UR]  = evt_valid && evt_underrange && rt[`EER_B_UR_TO_IRQ];
        st_set[`EER_F_OR]  = evt_valid && evt_overrange  && rt[`EER_B_OR_TO_IRQ];
        st_set[`EER_F_WD]  = evt_valid && evt_timeout    && rt[`EER_B_WD_TO_IRQ];
        st_set[`EER_F_AH]  = evt_valid && evt_amp_high   && rt[`EER_B_AH_TO_IRQ];
        st_set[`EER_F_AL]  = evt_valid && evt_amp_low    && rt[`EER_B_AL_TO_IRQ];
        st_set[`EER_F_ZC]  = evt_valid && evt_zero_count && rt[`EER_B_ZC_TO_IRQ];
        st_set[`EER_F_RDY] = data_ready_evt && rt[`EER_B_RDY_TO_IRQ];
        // Status read clears all; reading the source channel's result word clears errors
        st_clr = {7{status_rd}} | {{6{src_chan_rd}}, 1'b0};
    end

    always_comb begin
        res_set = '0;
        res_clr = '0;
        for (int c = 0; c < 4; c++) begin
            if (evt_valid && evt_onehot[c]) begin
                res_set[4*c+3] = evt_underrange && rt[`EER_B_UR_TO_RESULT];
                res_set[4*c+2] = evt_overrange && rt[`EER_B_OR_TO_RESULT];
                res_set[4*c+1] = evt_timeout && rt[`EER_B_WD_TO_RESULT];
                res_set[4*c+0] = (evt_amp_high && rt[`EER_B_AH_TO_RESULT]) ||
                                 (evt_amp_low && rt[`EER_B_AL_TO_RESULT]);
            end
            if (reg_rd && (reg_addr == result_hi_addr(eer_pkg::eer_chan_t'(c)))) begin
                res_clr[4*c +: 4] = 4'hf;
            end
        end
    end

    eer_flag_latch #(.WIDTH(7)) u_status_flags (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .set_vec (st_set),
        .clr_vec (st_clr),
        .flags   (st_flags)
    );

    eer_flag_latch #(.WIDTH(16)) u_result_flags (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .set_vec (res_set),
        .clr_vec (res_clr),
        .flags   (res_flags)
    );

    always_comb begin
        st_d = st_q;
        // Reserved bits are stored as written; the host keeps them zero
        if (reg_wr && (reg_addr == `EER_ADDR_ROUTING)) begin
            st_d.routing = reg_wdata;
        end
        if (|st_set[6:1]) begin
            st_d.src_chan = evt_channel;
        end
        if (data_ready_evt || !sequential_mode) begin
            st_d.seen = 4'h0;
        end else begin
            st_d.seen = seen_now;
        end
        st_d.hit   = reg_rd && ((reg_addr == `EER_ADDR_STATUS) ||
                                (reg_addr == `EER_ADDR_ROUTING));
        st_d.rdata = 16'h0000;
        if (reg_rd && (reg_addr == `EER_ADDR_STATUS)) begin
            st_d.rdata = status_word;
        end else if (reg_rd && (reg_addr == `EER_ADDR_ROUTING)) begin
            st_d.rdata = st_q.routing;
        end
        // Flags still latch while disabled; only the pin is held off
        st_d.irq_n = irq_pin_disable || !(|st_flags);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q         <= '0;
            st_q.routing <= `EER_ROUTING_RESET;
            st_q.irq_n   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_word = {st_q.src_chan, st_flags[6:1], 1'b0, st_flags[0], 6'h00};
    assign reg_rdata   = st_q.rdata;
    assign reg_hit     = st_q.hit;
    assign interrupt_out_n = st_q.irq_n;
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            result_underrange_flag[c] = res_flags[4*c+3];
            result_overrange_flag[c]  = res_flags[4*c+2];
            result_timeout_flag[c]    = res_flags[4*c+1];
            result_amplitude_flag[c]  = res_flags[4*c+0];
        end
    end

    property p_ur_result;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_underrange && rt[15] |=> result_underrange_flag[$past(evt_channel)];
    endproperty
    a_ur_result: assert property (p_ur_result) else $error("under-range result flag missed");

    property p_or_result;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(|result_overrange_flag) |-> $past(rt[14]);
    endproperty
    a_or_result: assert property (p_or_result) else $error("over-range flag set unrouted");

    property p_wd_result;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_timeout && !rt[13] && result_timeout_flag == 4'h0
        |=> result_timeout_flag == 4'h0;
    endproperty
    a_wd_result: assert property (p_wd_result) else $error("timeout flag set unrouted");

    property p_ah_result;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_amp_high && rt[12] |=> result_amplitude_flag[$past(evt_channel)];
    endproperty
    a_ah_result: assert property (p_ah_result) else $error("amp-high result flag missed");

    property p_al_result;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_amp_low && rt[11] |=> result_amplitude_flag[$past(evt_channel)];
    endproperty
    a_al_result: assert property (p_al_result) else $error("amp-low result flag missed");

    property p_ur_status;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_underrange && rt[7] |=> status_word[13];
    endproperty
    a_ur_status: assert property (p_ur_status) else $error("status under-range missed");

    property p_or_status;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(status_word[12]) |-> $past(rt[6] && evt_valid && evt_overrange);
    endproperty
    a_or_status: assert property (p_or_status) else $error("status over-range unrouted");

    property p_zc_status;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_zero_count && rt[2] |=> status_word[8];
    endproperty
    a_zc_status: assert property (p_zc_status) else $error("status zero-count missed");

    property p_rdy_status;
        @(posedge clk_sys) disable iff (!reset_n)
        conv_done && !sequential_mode && rt[0] |=> status_word[6];
    endproperty
    a_rdy_status: assert property (p_rdy_status) else $error("data-ready missed");

    property p_clear_cause;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(|status_word[13:8]) |-> $past(status_rd || src_chan_rd);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("error dropped without read");

    property p_src_chan;
        @(posedge clk_sys) disable iff (!reset_n)
        evt_valid && evt_timeout && rt[5] |=> status_word[15:14] == $past(evt_channel);
    endproperty
    a_src_chan: assert property (p_src_chan) else $error("error source channel wrong");

    property p_irq_dis;
        @(posedge clk_sys) disable iff (!reset_n)
        irq_pin_disable |=> interrupt_out_n;
    endproperty
    a_irq_dis: assert property (p_irq_dis) else $error("interrupt pin low while disabled");

    property p_irq_low;
        @(posedge clk_sys) disable iff (!reset_n)
        (|st_flags) && !irq_pin_disable |=> !interrupt_out_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt pin not asserted");
endmodule
`default_nettype wire

// >>> eer_host_model.sv
/*
 * Host side of the register engine: one-cycle write and read strobes.
 * Assumes the block samples strobes on the rising edge of clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module eer_host_model (
    input  wire logic               clk_sys,
    output eer_pkg::eer_addr_t      reg_addr,
    output eer_pkg::eer_word_t      reg_wdata,
    output logic                    reg_wr,
    output logic                    reg_rd,
    input  wire eer_pkg::eer_word_t reg_rdata,
    input  wire logic               reg_hit
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle address and data flip so a stale value never looks valid
    task automatic wr(input eer_pkg::eer_addr_t a, input eer_pkg::eer_word_t d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d & 16'hf8fd;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input eer_pkg::eer_addr_t a, output eer_pkg::eer_word_t d,
                      output logic h);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        h = reg_hit;
    endtask
endmodule
`default_nettype wire

// >>> error_event_routing_tb_top.sv
/*
 * Self-checking bench for the error and event routing block.
 * Assumes the host model drives the register strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "eer_params.svh"
module error_event_routing_tb_top;
    logic               clk_sys = 1'b0;
    logic               reset_n = 1'b0;
    eer_pkg::eer_addr_t reg_addr;
    eer_pkg::eer_word_t reg_wdata, reg_rdata, status_word, rd_d;
    logic               reg_wr, reg_rd, reg_hit, rd_h, interrupt_out_n;
    logic               evt_valid = 1'b0, conv_done = 1'b0, seq = 1'b0, dis = 1'b0;
    logic [5:0]         ev = 6'h00;
    eer_pkg::eer_chan_t evt_channel = 2'h0, conv_channel = 2'h0;
    logic [3:0]         act = 4'h0, r_ur, r_or, r_wd, r_am;
    int                 failures = 0, cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    eer_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
    eer_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .evt_valid(evt_valid), .evt_channel(evt_channel),
        .evt_underrange(ev[0]), .evt_overrange(ev[1]), .evt_timeout(ev[2]),
        .evt_amp_high(ev[3]), .evt_amp_low(ev[4]), .evt_zero_count(ev[5]),
        .conv_done(conv_done), .conv_channel(conv_channel), .sequential_mode(seq),
        .active_channels(act), .irq_pin_disable(dis), .result_underrange_flag(r_ur),
        .result_overrange_flag(r_or), .result_timeout_flag(r_wd),
        .result_amplitude_flag(r_am), .status_word(status_word),
        .interrupt_out_n(interrupt_out_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic pin(input logic e);
        chk({15'h0000, interrupt_out_n}, {15'h0000, e}, "interrupt pin");
    endtask
    // Flags return to the inverse after the strobe, since they are unqualified then
    task automatic fire(input logic [5:0] k, input eer_pkg::eer_chan_t c);
        @(negedge clk_sys);
        evt_valid = 1'b1;
        ev = k;
        evt_channel = c;
        @(negedge clk_sys);
        evt_valid = 1'b0;
        ev = ~k;
        evt_channel = ~c;
    endtask
    task automatic conv(input eer_pkg::eer_chan_t c);
        @(negedge clk_sys);
        conv_done = 1'b1;
        conv_channel = c;
        @(negedge clk_sys);
        conv_done = 1'b0;
        conv_channel = ~c;
    endtask
    task automatic clear_status;
        u_host.rd(`EER_ADDR_STATUS, rd_d, rd_h);
        @(negedge clk_sys);
        chk({2'h0, status_word[13:0]}, 16'h0000, "status after read");
        pin(1'b1);
    endtask
    task automatic t_regs;
        u_host.rd(`EER_ADDR_ROUTING, rd_d, rd_h);
        chk(rd_d, `EER_ROUTING_RESET, "routing reset");
        chk({15'h0000, rd_h}, 16'h0001, "routing hit");
        u_host.wr(`EER_ADDR_ROUTING, 16'hffff);
        u_host.wr(8'h30, 16'h0000);
        u_host.rd(`EER_ADDR_ROUTING, rd_d, rd_h);
        chk(rd_d, 16'hf8fd, "routing readback");
        u_host.rd(8'h30, rd_d, rd_h);
        chk({rd_d[15:1], rd_h}, 16'h0000, "unmapped read");
    endtask
    task automatic t_irq;
        for (int k = 0; k < 6; k++) begin
            u_host.wr(`EER_ADDR_ROUTING, 16'h0000);
            fire(6'h01 << k, 2'(k));
            @(negedge clk_sys);
            // An unrouted error must leave the source channel of the previous one
            chk(status_word, {((k == 0) ? 2'h0 : 2'(k - 1)), 14'h0000},
                "unrouted status");
            pin(1'b1);
            u_host.wr(`EER_ADDR_ROUTING, 16'h0080 >> k);
            fire(6'h01 << k, 2'(k));
            chk(status_word, {2'(k), 14'h2000 >> k}, "routed status");
            @(negedge clk_sys);
            pin(1'b0);
            u_host.rd(`EER_ADDR_STATUS, rd_d, rd_h);
            chk(rd_d, {2'(k), 14'h2000 >> k}, "status read");
            @(negedge clk_sys);
            chk({2'h0, status_word[13:0]}, 16'h0000, "status cleared");
            pin(1'b1);
        end
    endtask
    task automatic t_result;
        for (int k = 0; k < 5; k++) begin
            u_host.wr(`EER_ADDR_ROUTING, 16'h0000);
            fire(6'h01 << k, 2'(k + 1));
            chk({r_ur, r_or, r_wd, r_am}, 16'h0000, "unrouted result");
            u_host.wr(`EER_ADDR_ROUTING, 16'h8000 >> k);
            fire(6'h01 << k, 2'(k + 1));
            chk({r_ur, r_or, r_wd, r_am}, 16'h0001 << ((k < 4 ? 3 - k : 0) * 4 + (k + 1) % 4),
                "routed result");
            u_host.rd(8'(2 * ((k + 1) % 4)), rd_d, rd_h);
            chk({r_ur, r_or, r_wd, r_am}, 16'h0000, "result cleared");
        end
    endtask
    task automatic t_ready;
        u_host.wr(`EER_ADDR_ROUTING, 16'h0000);
        conv(2'h1);
        // Source channel 1 stays from the last routed error of the interrupt scenario
        chk(status_word, 16'h4000, "ready unrouted");
        u_host.wr(`EER_ADDR_ROUTING, 16'h0001);
        conv(2'h1);
        chk(status_word & 16'h0040, 16'h0040, "ready single");
        @(negedge clk_sys);
        pin(1'b0);
        clear_status();
        seq = 1'b1;
        act = 4'h5;
        conv(2'h0);
        chk(status_word & 16'h0040, 16'h0000, "ready partial scan");
        conv(2'h2);
        chk(status_word & 16'h0040, 16'h0040, "ready full scan");
        clear_status();
        seq = 1'b0;
    endtask
    task automatic t_disable;
        u_host.wr(`EER_ADDR_ROUTING, 16'h0080);
        dis = 1'b1;
        fire(6'h01, 2'h3);
        @(negedge clk_sys);
        chk(status_word, 16'he000, "flag with pin disabled");
        pin(1'b1);
        clear_status();
        dis = 1'b0;
    endtask
    task automatic t_result_clear;
        u_host.wr(`EER_ADDR_ROUTING, 16'h0040);
        fire(6'h02, 2'h1);
        u_host.rd(`EER_ADDR_RESULT_HI0, rd_d, rd_h);
        chk(status_word, 16'h5000, "other channel read keeps");
        u_host.rd(`EER_ADDR_RESULT_HI0 + `EER_ADDR_RESULT_STEP, rd_d, rd_h);
        @(negedge clk_sys);
        chk({2'h0, status_word[13:0]}, 16'h0000, "source channel read clears");
        pin(1'b1);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        chk({status_word[15:1], interrupt_out_n}, 16'h0001, "reset state");
        t_regs();
        t_irq();
        t_result();
        t_ready();
        t_disable();
        t_result_clear();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
